// >>> include/eivs_defines.svh
// Purpose: Offsets, field positions, reset values and counts for eivs.
// Assumes: Register offsets are word indexes; byte address is index * 4.
// Notes:   Included by its bare name from the package, the checker and the bench.
`ifndef EIVS_DEFINES_SVH
`define EIVS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define EIVS_IDX_PC_FLAG      8'h3B
`define EIVS_IDX_EXT_FLAG     8'h3C
`define EIVS_IDX_EXT_MASK     8'h3D
`define EIVS_IDX_MCU_CTRL     8'h55
`define EIVS_IDX_PC_ENABLE    8'h68
`define EIVS_IDX_SENSE_LOW    8'h69
`define EIVS_IDX_SENSE_HIGH   8'h6A
`define EIVS_IDX_PC_MASK0     8'h6B
`define EIVS_IDX_PC_MASK1     8'h6C
`define EIVS_IDX_PC_MASK2     8'h6D

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define EIVS_MCU_UNLOCK_BIT   0
`define EIVS_MCU_SELECT_BIT   1
`define EIVS_RESET_BYTE       8'h00
`define EIVS_SENSE_LEVEL      2'h0
`define EIVS_SENSE_ANY        2'h1
`define EIVS_SENSE_FALL       2'h2
`define EIVS_SENSE_RISE       2'h3

// ----------------------------------------------------------------------
// Vector placement and timing
// ----------------------------------------------------------------------
`define EIVS_APP_BASE         17'h00000
`define EIVS_BOOT_BASE_8K     17'h1F000
`define EIVS_BOOT_BASE_4K     17'h1F800
`define EIVS_BOOT_BASE_2K     17'h1FC00
`define EIVS_BOOT_BASE_1K     17'h1FE00
`define EIVS_VEC_ENTRY_WORDS  17'h00002
`define EIVS_UNLOCK_CYCLES    3'h4

`endif

// >>> include/eivs_pkg.sv
// Purpose: Types shared by the eivs block.
// Assumes: Constants live in eivs_defines.svh.
// Notes:   Nothing here is imported; users write eivs_pkg::name.
`include "eivs_defines.svh"

package eivs_pkg;

    // Unlock sequence states, Gray coded along idle, open, hold.
    typedef enum logic [1:0] {
        EIVS_IDLE = 2'h0,
        EIVS_OPEN = 2'h1,
        EIVS_HOLD = 2'h3
    } eivs_state_t;

    // One bit per request source, external pins then pin-change groups.
    typedef struct packed {
        logic [2:0] pc;
        logic [7:0] ext;
    } eivs_irq_t;

endpackage : eivs_pkg

// >>> logic/eivs_top.sv
// Purpose: External interrupt front end with vector table placement.
// Assumes: APB slave, zero wait states; pins synchronous to i_ref_clk.
// Notes:   Pin activity is sampled every clock so detection never waits
//          for the I/O clock enable, except the clocked upper edges.
// Notes on behaviour
// - Select zero puts vectors at flash start, one at boot start.
// - Boot start, hence relocated base, follows the boot size fuses.
// - Eight Kbyte boot section gives base 0x1F000, two words per entry.
// - Unlock clears itself after four cycles or on the select write.
// - Requests blocked from unlock until after next instruction, or four.
// - Blocking leaves the global interrupt enable untouched.
// - Boot vectors plus app lock suppress requests while in application.
// - App vectors plus boot lock suppress requests while in boot code.
// - Pin activity triggers even when pins are driven as outputs.
// - Group two covers inputs 23:16, one 15:8, zero 7:0.
// - Per-group masks choose which pins feed each group.
// - Pin changes are caught without needing the I/O clock.
// - Each pin senses low, any change, fall or rise; low reg 3:0, high reg 7:4.
// - Level mode keeps requesting while the pin stays low.
// - Edges on inputs 7:4 are seen only while the I/O clock runs.
// - Levels on all pins and edges on 3:0 need no I/O clock.
// - No I/O clock in deep sleep disables the clocked edge detection.
// - Level that vanishes before start-up ends raises no request.
// - Sense codes: 00 low, 01 any change, 10 falling, 11 rising.
// - Flags set on trigger, clear on vectoring or a written one.
// - Flags of level sensed pins are held clear.
// - Request needs its mask bit and the global enable.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module eivs_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [7:0]        i_ext_irq_pins,
    input  wire logic [23:0]       i_pin_change_inputs,
    input  wire logic              i_io_clk_en,
    input  wire logic              i_startup_done,
    input  wire logic              i_global_irq_enable,
    input  wire logic [1:0]        i_boot_size_fuses,
    input  wire logic              i_app_side_lock_bit,
    input  wire logic              i_boot_side_lock_bit,
    input  wire logic              i_exec_in_boot,
    input  wire logic              i_instr_done,
    input  wire logic [10:0]       i_irq_ack,
    output eivs_pkg::eivs_irq_t    o_irq_req,
    output logic      [16:0]       o_vector_base,
    output logic      [16:0]       o_vector_addr,
    output logic                   o_irq_blocked
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    eivs_pkg::eivs_state_t state_reg, state_next;
    eivs_pkg::eivs_irq_t   req_reg, req_next;
    logic [2:0]  count_reg, count_next;
    logic        select_reg, select_next;
    logic        unlock_reg, unlock_next;
    logic [7:0]  mask_reg, mask_next;
    logic [7:0]  flag_reg, flag_next;
    logic [7:0]  sense_lo_reg, sense_lo_next;
    logic [7:0]  sense_hi_reg, sense_hi_next;
    logic [2:0]  pc_en_reg, pc_en_next;
    logic [2:0]  pc_flag_reg, pc_flag_next;
    logic [23:0] pc_mask_reg, pc_mask_next;
    logic [7:0]  ext_s1_reg, ext_s2_reg, ext_prev_reg, ext_prev_next;
    logic [23:0] pc_s1_reg, pc_s2_reg, pc_prev_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic        err_reg, err_next;
    logic        ready_reg;
    logic        blocked_reg, blocked_next;
    logic [16:0] base_reg, base_next;
    logic [16:0] vaddr_reg, vaddr_next;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [7:0] idx;
    logic       aligned;
    logic       setup_ph;
    logic       wr_ph;
    logic [7:0] wbyte;

    assign idx      = paddr[9:2];
    assign aligned  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    assign setup_ph = psel && !penable;
    assign wr_ph    = psel && penable && pwrite && aligned;
    assign wbyte    = pwdata[7:0];

    // Decode one index into a hit flag; unmapped words answer an error.
    function automatic logic mapped(input logic [7:0] i);
        case (i)
            `EIVS_IDX_PC_FLAG, `EIVS_IDX_EXT_FLAG, `EIVS_IDX_EXT_MASK,
            `EIVS_IDX_MCU_CTRL, `EIVS_IDX_PC_ENABLE, `EIVS_IDX_SENSE_LOW,
            `EIVS_IDX_SENSE_HIGH, `EIVS_IDX_PC_MASK0, `EIVS_IDX_PC_MASK1,
            `EIVS_IDX_PC_MASK2: mapped = 1'b1;
            default:            mapped = 1'b0;
        endcase
    endfunction : mapped

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Requests use the next blocking state, so the unlock write itself
    // already blocks and no request slips out on that edge.
    always_comb begin
        logic [1:0]  mode;
        logic        pin;
        logic        old;
        logic        hit;
        logic [23:0] toggles;
        logic        suppress;
        logic        sel_wr;
        int          k;
        mode          = 2'h0;
        pin           = 1'b0;
        old           = 1'b0;
        hit           = 1'b0;
        toggles       = 24'h000000;
        suppress      = 1'b0;
        sel_wr        = 1'b0;
        k             = 0;
        state_next    = state_reg;
        count_next    = count_reg;
        select_next   = select_reg;
        unlock_next   = unlock_reg;
        mask_next     = mask_reg;
        sense_lo_next = sense_lo_reg;
        sense_hi_next = sense_hi_reg;
        pc_en_next    = pc_en_reg;
        pc_mask_next  = pc_mask_reg;
        flag_next     = flag_reg;
        pc_flag_next  = pc_flag_reg;
        ext_prev_next = ext_prev_reg;

        // Plain control registers.
        if (wr_ph) begin
            case (idx)
                `EIVS_IDX_EXT_MASK:   mask_next = wbyte;
                `EIVS_IDX_SENSE_LOW:  sense_lo_next = wbyte;
                `EIVS_IDX_SENSE_HIGH: sense_hi_next = wbyte;
                `EIVS_IDX_PC_ENABLE:  pc_en_next = wbyte[2:0];
                `EIVS_IDX_PC_MASK0:   pc_mask_next[7:0] = wbyte;
                `EIVS_IDX_PC_MASK1:   pc_mask_next[15:8] = wbyte;
                `EIVS_IDX_PC_MASK2:   pc_mask_next[23:16] = wbyte;
                default:              ;
            endcase
        end

        sel_wr = wr_ph && (idx == `EIVS_IDX_MCU_CTRL);
        case (state_reg)
            eivs_pkg::EIVS_IDLE: begin
                if (sel_wr && wbyte[`EIVS_MCU_UNLOCK_BIT]) begin
                    state_next  = eivs_pkg::EIVS_OPEN;
                    unlock_next = 1'b1;
                    count_next  = `EIVS_UNLOCK_CYCLES - 3'h1;
                end
            end
            eivs_pkg::EIVS_OPEN: begin
                if (sel_wr && !wbyte[`EIVS_MCU_UNLOCK_BIT]) begin
                    select_next = wbyte[`EIVS_MCU_SELECT_BIT];
                    unlock_next = 1'b0;
                    state_next  = eivs_pkg::EIVS_HOLD;
                end else if (sel_wr) begin
                    count_next  = `EIVS_UNLOCK_CYCLES - 3'h1;
                end else if (count_reg == 3'h0) begin
                    unlock_next = 1'b0;
                    state_next  = eivs_pkg::EIVS_IDLE;
                end else begin
                    count_next  = count_reg - 3'h1;
                end
            end
            eivs_pkg::EIVS_HOLD: begin
                if (i_instr_done) begin
                    state_next = eivs_pkg::EIVS_IDLE;
                end
            end
            default: begin
                state_next  = eivs_pkg::EIVS_IDLE;
                unlock_next = 1'b0;
            end
        endcase

        if (wr_ph && idx == `EIVS_IDX_EXT_FLAG) begin
            flag_next = flag_next & ~wbyte;
        end
        if (wr_ph && idx == `EIVS_IDX_PC_FLAG) begin
            pc_flag_next = pc_flag_next & ~wbyte[2:0];
        end
        flag_next    = flag_next & ~i_irq_ack[7:0];
        pc_flag_next = pc_flag_next & ~i_irq_ack[10:8];

        ext_prev_next[3:0] = ext_s2_reg[3:0];
        if (i_io_clk_en) begin
            ext_prev_next[7:4] = ext_s2_reg[7:4];
        end

        for (k = 0; k < 8; k++) begin
            mode = (k < 4) ? sense_lo_reg[2*(k%4) +: 2]
                           : sense_hi_reg[2*(k%4) +: 2];
            pin  = ext_s2_reg[k];
            old  = ext_prev_reg[k];
            hit  = 1'b0;
            if (k < 4 || i_io_clk_en) begin
                case (mode)
                    `EIVS_SENSE_ANY:  hit = pin ^ old;
                    `EIVS_SENSE_FALL: hit = old && !pin;
                    `EIVS_SENSE_RISE: hit = pin && !old;
                    default:          hit = 1'b0;
                endcase
            end
            // Set wins over any clear in the same cycle.
            // level mode flag clear
            flag_next[k] = (flag_next[k] || hit)
                        && (mode != `EIVS_SENSE_LEVEL);
        end

        toggles = (pc_s2_reg ^ pc_prev_reg) & pc_mask_reg;
        pc_flag_next = pc_flag_next
                     | {|toggles[23:16], |toggles[15:8], |toggles[7:0]};

        blocked_next = (state_next != eivs_pkg::EIVS_IDLE);

        suppress = (select_next && i_app_side_lock_bit && !i_exec_in_boot)
                || (!select_next && i_boot_side_lock_bit && i_exec_in_boot);

        for (k = 0; k < 8; k++) begin
            mode = (k < 4) ? sense_lo_reg[2*(k%4) +: 2]
                           : sense_hi_reg[2*(k%4) +: 2];
            if (mode == `EIVS_SENSE_LEVEL) begin
                req_next.ext[k] = !ext_s2_reg[k] && i_startup_done;
            end else begin
                req_next.ext[k] = flag_next[k];
            end
        end
        req_next.ext = req_next.ext & mask_reg;
        req_next.pc  = pc_flag_next & pc_en_reg;
        if (!i_global_irq_enable || blocked_next || suppress) begin
            req_next = '0;
        end

        if (!select_next) begin
            base_next = `EIVS_APP_BASE;
        end else begin
            case (i_boot_size_fuses)
                2'h0:    base_next = `EIVS_BOOT_BASE_8K;
                2'h1:    base_next = `EIVS_BOOT_BASE_4K;
                2'h2:    base_next = `EIVS_BOOT_BASE_2K;
                default: base_next = `EIVS_BOOT_BASE_1K;
            endcase
        end

        // Lowest index wins; entry zero is reset, sources start at one.
        vaddr_next = base_next;
        for (k = 10; k >= 0; k--) begin
            if (req_next[k]) begin
                vaddr_next = base_next
                           + `EIVS_VEC_ENTRY_WORDS * 17'(k + 1);
            end
        end

        // Read data is latched in the setup phase; zero wait states.
        rdata_next = rdata_reg;
        err_next   = err_reg && !(psel && penable);
        if (setup_ph) begin
            err_next   = !aligned || !mapped(idx);
            rdata_next = 32'h00000000;
            case (aligned ? idx : 8'h00)
                `EIVS_IDX_PC_FLAG:    rdata_next[2:0] = pc_flag_reg;
                `EIVS_IDX_EXT_FLAG:   rdata_next[7:0] = flag_reg;
                `EIVS_IDX_EXT_MASK:   rdata_next[7:0] = mask_reg;
                `EIVS_IDX_MCU_CTRL:   rdata_next[1:0] = {select_reg,
                                                         unlock_reg};
                `EIVS_IDX_PC_ENABLE:  rdata_next[2:0] = pc_en_reg;
                `EIVS_IDX_SENSE_LOW:  rdata_next[7:0] = sense_lo_reg;
                `EIVS_IDX_SENSE_HIGH: rdata_next[7:0] = sense_hi_reg;
                `EIVS_IDX_PC_MASK0:   rdata_next[7:0] = pc_mask_reg[7:0];
                `EIVS_IDX_PC_MASK1:   rdata_next[7:0] = pc_mask_reg[15:8];
                `EIVS_IDX_PC_MASK2:   rdata_next[7:0] = pc_mask_reg[23:16];
                default:              rdata_next = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // two-flop pin synchroniser
    // Only the second stage feeds detection; the first is read only by the second.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            ext_s1_reg   <= 8'hFF;
            ext_s2_reg   <= 8'hFF;
            ext_prev_reg <= 8'hFF;
            pc_s1_reg    <= 24'h000000;
            pc_s2_reg    <= 24'h000000;
            pc_prev_reg  <= 24'h000000;
        end else begin
            ext_s1_reg   <= i_ext_irq_pins;
            ext_s2_reg   <= ext_s1_reg;
            ext_prev_reg <= ext_prev_next;
            pc_s1_reg    <= i_pin_change_inputs;
            pc_s2_reg    <= pc_s1_reg;
            pc_prev_reg  <= pc_s2_reg;
        end
    end

    // Control, flags and outputs.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            state_reg    <= eivs_pkg::EIVS_IDLE;
            count_reg    <= 3'h0;
            select_reg   <= 1'b0;
            unlock_reg   <= 1'b0;
            mask_reg     <= `EIVS_RESET_BYTE;
            flag_reg     <= `EIVS_RESET_BYTE;
            sense_lo_reg <= `EIVS_RESET_BYTE;
            sense_hi_reg <= `EIVS_RESET_BYTE;
            pc_en_reg    <= 3'h0;
            pc_flag_reg  <= 3'h0;
            pc_mask_reg  <= 24'h000000;
            req_reg      <= '0;
            rdata_reg    <= 32'h00000000;
            err_reg      <= 1'b0;
            ready_reg    <= 1'b0;
            blocked_reg  <= 1'b0;
            base_reg     <= `EIVS_APP_BASE;
            vaddr_reg    <= `EIVS_APP_BASE;
        end else begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            select_reg   <= select_next;
            unlock_reg   <= unlock_next;
            mask_reg     <= mask_next;
            flag_reg     <= flag_next;
            sense_lo_reg <= sense_lo_next;
            sense_hi_reg <= sense_hi_next;
            pc_en_reg    <= pc_en_next;
            pc_flag_reg  <= pc_flag_next;
            pc_mask_reg  <= pc_mask_next;
            req_reg      <= req_next;
            rdata_reg    <= rdata_next;
            err_reg      <= err_next;
            ready_reg    <= 1'b1;
            blocked_reg  <= blocked_next;
            base_reg     <= base_next;
            vaddr_reg    <= vaddr_next;
        end
    end

    assign prdata        = rdata_reg;
    assign pready        = ready_reg;
    assign pslverr       = err_reg;
    assign o_irq_req     = req_reg;
    assign o_vector_base = base_reg;
    assign o_vector_addr = vaddr_reg;
    assign o_irq_blocked = blocked_reg;

endmodule : eivs_top

`default_nettype wire

// >>> tb/eivs_checker.sv
// Purpose: Port-level assertions for eivs_top.
// Assumes: One clock domain, synchronous active low reset.
// Notes:   Bound from the testbench top file; sees top ports only.
`timescale 1ns/10ps
`default_nettype none
`include "eivs_defines.svh"
module eivs_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic                i_ref_clk,
    input wire logic                i_reset_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                i_global_irq_enable,
    input wire logic [1:0]          i_boot_size_fuses,
    input wire logic                i_app_side_lock_bit,
    input wire logic                i_exec_in_boot,
    input wire eivs_pkg::eivs_irq_t o_irq_req,
    input wire logic [16:0]         o_vector_base,
    input wire logic [16:0]         o_vector_addr,
    input wire logic                o_irq_blocked
);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    // A control register write in its access phase.
    wire logic mcu_wr = psel && penable && pwrite
        && paddr == {`EIVS_IDX_MCU_CTRL, 2'h0};
    // An unlock write from idle; a restart inside open is excluded.
    wire logic unl_wr = mcu_wr && pwdata[0] && !o_irq_blocked;
    property p_quiet;
        o_irq_blocked |-> o_irq_req == '0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("request while blocked");
    property p_open;
        unl_wr |=> o_irq_blocked [*2];
    endproperty
    a_open: assert property (p_open)
        else $error("unlock did not block");
    property p_expire;
        unl_wr ##1 !mcu_wr [*4] |=> !o_irq_blocked;
    endproperty
    a_expire: assert property (p_expire)
        else $error("unlock window not closed");
    property p_base_cause;
        $changed(o_vector_base) |-> $past(mcu_wr)
            || $past(i_boot_size_fuses) != $past(i_boot_size_fuses, 2);
    endproperty
    a_base_cause: assert property (p_base_cause)
        else $error("vector base moved without cause");
    property p_entry;
        $stable(o_vector_base) |-> !o_vector_addr[0]
            && (o_vector_addr - o_vector_base) <= 17'h00016;
    endproperty
    a_entry: assert property (p_entry)
        else $error("vector address off table");
    property p_global;
        !i_global_irq_enable |=> o_irq_req == '0;
    endproperty
    a_global: assert property (p_global)
        else $error("request without global enable");
    property p_app_lock;
        o_vector_base != 17'h00000 && i_app_side_lock_bit
            && !i_exec_in_boot |=> o_irq_req == '0;
    endproperty
    a_app_lock: assert property (p_app_lock)
        else $error("request in locked application");
    property p_base_legal;
        o_vector_base inside {17'h00000, `EIVS_BOOT_BASE_8K,
            `EIVS_BOOT_BASE_4K, `EIVS_BOOT_BASE_2K, `EIVS_BOOT_BASE_1K};
    endproperty
    a_base_legal: assert property (p_base_legal)
        else $error("vector base not a section start");
endmodule : eivs_checker
`default_nettype wire

// >>> tb/eivs_pin_model.sv
// Purpose: Pins of the part, driven as outputs by software.
// Assumes: Levels change only after a clock edge.
// Notes:   Change pins hold their value between flips.
`timescale 1ns/10ps
`default_nettype none
module eivs_pin_model (
    input  wire logic        i_ref_clk,
    input  wire logic [7:0]  i_ext_level,
    input  wire logic [23:0] i_pc_flip,
    output var logic  [7:0]  o_ext_pins = 8'hFF,
    output var logic  [23:0] o_pc_pins = 24'h000000
);
    // pins as outputs
    // Port latches drive the pins, so the block sees software activity.
    always @(posedge i_ref_clk) begin
        o_ext_pins <= i_ext_level;
        o_pc_pins  <= o_pc_pins ^ i_pc_flip;
    end
endmodule : eivs_pin_model
`default_nettype wire

// >>> tb/tb_eivs_top.sv
// Purpose: Self-checking bench for eivs_top.
// Assumes: APB answers without a fixed latency; pins via the pin model.
// Notes:   Reads queue their expected value; a monitor compares them.
`timescale 1ns/10ps
`default_nettype none
`include "eivs_defines.svh"
module tb_eivs_top;
    localparam logic [11:0] MCU = 12'h154, EFL = 12'h0F0, EMS = 12'h0F4;
    localparam logic [11:0] PCE = 12'h1A0, SLO = 12'h1A4, SHI = 12'h1A8;
    localparam logic [16:0] BASE [4] = '{`EIVS_BOOT_BASE_8K,
        `EIVS_BOOT_BASE_4K, `EIVS_BOOT_BASE_2K, `EIVS_BOOT_BASE_1K};
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, io_en = 1'h1, glb = 1'h1, su = 1'h1, ins = 1'h0;
    logic app_lk = 1'h0, boot_lk = 1'h0, in_boot = 1'h1;
    logic pready, pslverr, blk;
    logic [1:0]  fuse = 2'h0;
    logic [7:0]  lvl = 8'hFF, ext_pins;
    logic [10:0] ack = 11'h000;
    logic [11:0] paddr = 12'h000;
    logic [23:0] flip = 24'h000000, pc_pins;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [16:0] vbase, vaddr;
    logic [32:0] rdq [$];
    eivs_pkg::eivs_irq_t req;
    int error_cnt = 0, checks_done = 0, seed = 1157, cyc = 0, r;
    eivs_pin_model pm_u (.i_ref_clk(clk), .i_ext_level(lvl),
        .i_pc_flip(flip), .o_ext_pins(ext_pins), .o_pc_pins(pc_pins));
    eivs_top dut_u (.i_ref_clk(clk), .i_reset_n(rst_n), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .i_ext_irq_pins(ext_pins), .i_pin_change_inputs(pc_pins),
        .i_io_clk_en(io_en), .i_startup_done(su),
        .i_global_irq_enable(glb), .i_boot_size_fuses(fuse),
        .i_app_side_lock_bit(app_lk), .i_boot_side_lock_bit(boot_lk),
        .i_exec_in_boot(in_boot), .i_instr_done(ins), .i_irq_ack(ack),
        .o_irq_req(req), .o_vector_base(vbase), .o_vector_addr(vaddr),
        .o_irq_blocked(blk));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [32:0] s, e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // A read queues {slave error, data}; the request is held until pready.
    task automatic apb(input logic w, input logic [11:0] a, [32:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr} <= {1'h1, 1'h0, w, a};
        pwdata <= {24'h000000, d[7:0]};
        if (!w) rdq.push_back(d);
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        {psel, penable} <= 2'h0;
    endtask : apb
    // Bounded wait for a request bit; an expected zero waits the full span.
    task automatic wreq(input int b, input logic e);
        for (int n = 0; n < 20 && req[b] !== 1'h1; n++) @(posedge clk);
        chk("request", req[b], e);
    endtask : wreq
    task automatic pulse(input int ib, ab, fb);
        @(posedge clk);
        {ins, ack, flip} <= {ib[0], 11'h001 << ab, 24'h000001 << fb};
        @(posedge clk);
        {ins, ack, flip} <= '0;
    endtask : pulse
    // Clock, timeout and read monitor.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end else if (psel && penable && pready && !pwrite && rdq.size() > 0)
            chk("read", {pslverr, prdata}, rdq.pop_front());
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        apb(0, MCU, 0);
        apb(0, 12'h3FC, {1'h1, 32'h0});
        apb(0, 12'h155, {1'h1, 32'h0});
        $display("test reset and refusals done");
        for (int f = 0; f < 4; f++) begin
            fuse <= f[1:0];
            apb(1, MCU, 1);
            #1 chk("blocked", blk, 1);
            apb(1, MCU, 2);
            #1 chk("base", vbase, BASE[f]);
            apb(0, MCU, 2);
            pulse(1, 11, 24);
            @(posedge clk) chk("blocked", blk, 0);
        end
        fuse <= 2'h0;
        apb(1, MCU, 1);
        repeat (4) @(posedge clk);
        #1 chk("blocked", blk, 0);
        apb(1, MCU, 0);
        #1 chk("base", vbase, 17'h1F000);
        $display("test vector placement done");
        apb(1, EMS, 8'hFF);
        apb(1, SLO, 8'h1E);
        apb(1, SHI, 8'h02);
        {lvl, su} <= {8'hF0, 1'h0};
        wreq(0, 1);
        chk("vector", vaddr, 17'h1F002);
        wreq(3, 0);
        su <= 1'h1;
        wreq(3, 1);
        wreq(2, 1);
        wreq(1, 0);
        apb(0, EFL, 8'h05);
        pulse(0, 0, 24);
        apb(1, EFL, 8'h04);
        lvl <= 8'hFF;
        wreq(1, 1);
        apb(0, EFL, 8'h06);
        chk("level", req[3], 0);
        apb(1, EFL, 8'hFF);
        {io_en, lvl} <= {1'h0, 8'hEF};
        wreq(4, 0);
        lvl <= 8'hFF;
        repeat (5) @(posedge clk);
        {io_en, lvl} <= {1'h1, 8'hEF};
        wreq(4, 1);
        $display("test dedicated pins done");
        apb(1, PCE, 8'h07);
        for (int g = 0; g < 3; g++) begin
            r = $unsigned($random(seed)) % 8;
            apb(1, 12'h1AC + 12'(4 * g), 8'h01 << r);
            pulse(0, 11, 8 * g + (r + 1) % 8);
            wreq(8 + g, 0);
            pulse(0, 11, 8 * g + r);
            wreq(8 + g, 1);
            pulse(0, 8 + g, 24);
        end
        glb <= 1'h0;
        pulse(0, 11, 16 + r);
        wreq(10, 0);
        glb <= 1'h1;
        wreq(10, 1);
        pulse(0, 10, 24);
        {app_lk, boot_lk, in_boot} <= 3'h6;
        pulse(0, 11, 16 + r);
        wreq(10, 0);
        in_boot <= 1'h1;
        wreq(10, 1);
        apb(1, MCU, 1);
        apb(1, MCU, 0);
        pulse(1, 11, 24);
        wreq(10, 0);
        $display("test pin change and locks done");
        stop_test();
    end
endmodule : tb_eivs_top
bind eivs_top eivs_checker #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire
